// file: stack_core_pkg.sv
// Purpose: shared constants and types for the stack core datapath
// Assumes: one core clock, primitive operations issued by the sequencer
// Notes: addresses are 9 bits; bit 8 set selects ports
package stack_core_pkg;
    localparam int WORD_W = 18;
    localparam int STACK_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int ADDR_W = 9;
    localparam int B_W = 9;
    localparam int P_W = 10;
    localparam int MEM_WORDS = 64;
    localparam int MEM_IDX_W = 6;
    localparam int INC_W = 7;
    localparam int PORT_BIT = 8;
    localparam int ROM_BIT = 7;
    localparam int EXT_BIT = 9;
    localparam logic [B_W-1:0] B_RESET = 9'h15D;
    localparam logic [WORD_W-1:0] WORD_ZERO = 18'h00000;
    localparam logic [P_W-1:0] P_RESET = 10'h000;
    localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
    localparam logic [INC_W-1:0] INC_ONE = 7'h01;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_DUP = 5'h01,
        OP_DROP = 5'h02,
        OP_OVER = 5'h03,
        OP_PUSH = 5'h04,
        OP_POP = 5'h05,
        OP_A_READ = 5'h06,
        OP_A_WRITE = 5'h07,
        OP_B_WRITE = 5'h08,
        OP_FETCH_A = 5'h09,
        OP_FETCH_A_INC = 5'h0A,
        OP_STORE_A = 5'h0B,
        OP_STORE_A_INC = 5'h0C,
        OP_FETCH_B = 5'h0D,
        OP_STORE_B = 5'h0E,
        OP_FETCH_P_INC = 5'h0F,
        OP_STORE_P_INC = 5'h10,
        OP_NOT = 5'h11,
        OP_AND = 5'h12,
        OP_XOR = 5'h13,
        OP_ADD = 5'h14,
        OP_MUL_STEP = 5'h15,
        OP_SHL = 5'h16,
        OP_SHR = 5'h17
    } op_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } port_req_s;

    typedef struct packed {
        logic wr;
        logic [MEM_IDX_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } rom_load_s;
endpackage

// file: stack_core_datapath.sv
// Purpose: datapath of one stack-machine core: stacks, A/B/P, local memory, ALU
// Assumes: one operation per cycle when op_valid; inputs synchronous to core_clk
// Notes: ROM content is loaded through the rom_load port before use
// How it works
// - both stacks are eight-entry rings; pointers wrap, cells cleared only by reset, no errors
// - duplicate pushes a copy of T so T and S equal old T
// - discard pops the data stack, S becomes T
// - copy-second pushes a copy of S above the two unchanged items
// - move-to-return pops T and pushes it into R
// - move-from-return pops R and pushes it onto the data stack
// - A is 18 bits read/write; B is 9 bits write-only
// - reset loads B with the control and status address
// - read-A pushes A, A unchanged
// - write-A pops T into A
// - write-B pops T, keeping only its low nine bits
// - 64 words RAM at 0x00-0x3F and 64 words ROM at 0x80-0xBF
// - address bit 6 is not decoded, so upper halves alias
// - fetch-via-A pushes the addressed location, A unchanged
// - A auto-increment only for memory, wrapping 0x7F to 0x00, 0xFF to 0x80
// - fetch/store via B use B unchanged; the store pops
// - P access then increment for memory only, same wrap as A
// - invert T; AND and XOR of T and S leave one result
// - add replaces T and S with their sum, carry kept in standard mode
// - multiply step: multiplicand S, multiplier A, low word A, high word T
// - doubling is arithmetic left shift; halving keeps the sign
// - multiply step adds S to T when A lsb set, then shifts T.A right
// - P bit 9 selects extended mode; otherwise carry never changes
// - extended add includes the carry and latches the new carry out
`timescale 1ns/1ns
`default_nettype none

module stack_core_datapath #(
    parameter int DEPTH = stack_core_pkg::STACK_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire stack_core_pkg::op_e op,
    input wire logic p_load,
    input wire logic [stack_core_pkg::P_W-1:0] p_load_value,
    input wire stack_core_pkg::rom_load_s rom_load,
    input wire logic [stack_core_pkg::WORD_W-1:0] port_rdata,
    output stack_core_pkg::port_req_s port_req,
    output logic [stack_core_pkg::WORD_W-1:0] t,
    output logic [stack_core_pkg::WORD_W-1:0] s,
    output logic [stack_core_pkg::WORD_W-1:0] r,
    output logic [stack_core_pkg::WORD_W-1:0] a,
    output logic [stack_core_pkg::B_W-1:0] b,
    output logic [stack_core_pkg::P_W-1:0] p,
    output logic carry,
    output logic ext_mode
);
    localparam int W = stack_core_pkg::WORD_W;
    localparam int PW = stack_core_pkg::PTR_W;
    localparam int AW = stack_core_pkg::ADDR_W;
    localparam int IW = stack_core_pkg::INC_W;
    logic [W-1:0] dstk [DEPTH];
    logic [W-1:0] rstk [DEPTH];
    logic [PW-1:0] dsp;
    logic [PW-1:0] rsp;
    logic [W-1:0] ram [stack_core_pkg::MEM_WORDS];
    logic [W-1:0] rom [stack_core_pkg::MEM_WORDS];
    logic [W-1:0] next_t;
    logic [W-1:0] next_s;
    logic [W-1:0] next_r;
    logic [W-1:0] next_a;
    logic [stack_core_pkg::P_W-1:0] next_p;
    logic next_carry;
    logic d_push;
    logic d_pop;
    logic r_push;
    logic r_pop;
    logic b_write;
    logic mem_access;
    logic mem_write;
    logic [AW-1:0] eff_addr;
    logic [W-1:0] rd_data;
    logic [W:0] add_sum;
    logic [W:0] mul_sum;
    logic [W-1:0] mul_hi;
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] adr);
        logic [AW-1:0] res;
        res = adr;
        if (!adr[stack_core_pkg::PORT_BIT]) begin
            res[IW-1:0] = adr[IW-1:0] + stack_core_pkg::INC_ONE;
        end
        return res;
    endfunction

    assign ext_mode = p[stack_core_pkg::EXT_BIT];
    assign eff_addr = (op inside {stack_core_pkg::OP_FETCH_B, stack_core_pkg::OP_STORE_B}) ? b :
        (op inside {stack_core_pkg::OP_FETCH_P_INC, stack_core_pkg::OP_STORE_P_INC}) ? p[AW-1:0] : a[AW-1:0];
    // only loads and stores reach memory or a port
    assign mem_write = op_valid && (op inside {stack_core_pkg::OP_STORE_A, stack_core_pkg::OP_STORE_A_INC,
        stack_core_pkg::OP_STORE_B, stack_core_pkg::OP_STORE_P_INC});
    assign mem_access = mem_write || (op_valid && (op inside {stack_core_pkg::OP_FETCH_A,
        stack_core_pkg::OP_FETCH_A_INC, stack_core_pkg::OP_FETCH_B, stack_core_pkg::OP_FETCH_P_INC}));

    // bit 6 ignored by the decode
    always_comb begin
        if (eff_addr[stack_core_pkg::PORT_BIT]) begin
            rd_data = port_rdata;
        end else if (eff_addr[stack_core_pkg::ROM_BIT]) begin
            rd_data = rom[eff_addr[stack_core_pkg::MEM_IDX_W-1:0]];
        end else begin
            rd_data = ram[eff_addr[stack_core_pkg::MEM_IDX_W-1:0]];
        end
    end

    // port side is combinational so a port answers within the operation's cycle
    always_comb begin
        port_req.rd = mem_access && !mem_write && eff_addr[stack_core_pkg::PORT_BIT];
        port_req.wr = mem_write && eff_addr[stack_core_pkg::PORT_BIT];
        port_req.addr = eff_addr;
        port_req.wdata = t;
    end

    // carry enters only in extended mode
    assign add_sum = {1'b0, t} + {1'b0, s} + {{W{1'b0}}, carry && ext_mode};
    // sign-extended add of S into T before the shift
    assign mul_sum = a[0] ? ({t[W-1], t} + {s[W-1], s}) : {t[W-1], t};
    assign mul_hi = mul_sum[W:1];

    always_comb begin
        next_t = t;
        next_s = s;
        next_r = r;
        next_a = a;
        next_p = p;
        next_carry = carry;
        d_push = 1'b0;
        d_pop = 1'b0;
        r_push = 1'b0;
        r_pop = 1'b0;
        b_write = 1'b0;
        if (op_valid) begin
            unique case (op)
                stack_core_pkg::OP_DUP: d_push = 1'b1;
                stack_core_pkg::OP_DROP: d_pop = 1'b1;
                stack_core_pkg::OP_OVER: begin
                    d_push = 1'b1;
                    next_t = s;
                end
                stack_core_pkg::OP_PUSH: begin
                    d_pop = 1'b1;
                    r_push = 1'b1;
                    next_r = t;
                end
                stack_core_pkg::OP_POP: begin
                    d_push = 1'b1;
                    next_t = r;
                    r_pop = 1'b1;
                end
                stack_core_pkg::OP_A_READ: begin
                    d_push = 1'b1;
                    next_t = a;
                end
                stack_core_pkg::OP_A_WRITE: begin
                    d_pop = 1'b1;
                    next_a = t;
                end
                stack_core_pkg::OP_B_WRITE: begin
                    d_pop = 1'b1;
                    b_write = 1'b1;
                end
                stack_core_pkg::OP_FETCH_A,
                stack_core_pkg::OP_FETCH_B: begin
                    d_push = 1'b1;
                    next_t = rd_data;
                end
                stack_core_pkg::OP_FETCH_A_INC: begin
                    d_push = 1'b1;
                    next_t = rd_data;
                    next_a = {a[W-1:AW], bump(a[AW-1:0])};
                end
                stack_core_pkg::OP_STORE_A,
                stack_core_pkg::OP_STORE_B: d_pop = 1'b1;
                stack_core_pkg::OP_STORE_A_INC: begin
                    d_pop = 1'b1;
                    next_a = {a[W-1:AW], bump(a[AW-1:0])};
                end
                stack_core_pkg::OP_FETCH_P_INC: begin
                    d_push = 1'b1;
                    next_t = rd_data;
                    next_p = {p[stack_core_pkg::P_W-1:AW], bump(p[AW-1:0])};
                end
                stack_core_pkg::OP_STORE_P_INC: begin
                    d_pop = 1'b1;
                    next_p = {p[stack_core_pkg::P_W-1:AW], bump(p[AW-1:0])};
                end
                stack_core_pkg::OP_NOT: next_t = ~t;
                stack_core_pkg::OP_AND: begin
                    d_pop = 1'b1;
                    next_t = t & s;
                end
                stack_core_pkg::OP_XOR: begin
                    d_pop = 1'b1;
                    next_t = t ^ s;
                end
                // add, carry only in extended mode
                stack_core_pkg::OP_ADD: begin
                    d_pop = 1'b1;
                    next_t = add_sum[W-1:0];
                    if (ext_mode) begin
                        next_carry = add_sum[W];
                    end
                end
                stack_core_pkg::OP_MUL_STEP: begin
                    next_t = mul_hi;
                    next_a = {mul_sum[0], a[W-1:1]};
                end
                stack_core_pkg::OP_SHL: next_t = {t[W-2:0], 1'b0};
                stack_core_pkg::OP_SHR: next_t = {t[W-1], t[W-1:1]};
                default: next_t = t;
            endcase
            if (d_push) begin
                next_s = t;
            end
            if (d_pop) begin
                next_s = dstk[dsp];
                if (!(op inside {stack_core_pkg::OP_AND, stack_core_pkg::OP_XOR, stack_core_pkg::OP_ADD})) begin
                    next_t = s;
                end
            end
            if (r_pop) begin
                next_r = rstk[rsp];
            end
        end
        if (p_load) begin
            next_p = p_load_value;
        end
    end

    // data ring: cells keep old data on pop
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dsp <= '0;
            t <= stack_core_pkg::WORD_ZERO;
            s <= stack_core_pkg::WORD_ZERO;
            for (int i = 0; i < DEPTH; i++) begin
                dstk[i] <= stack_core_pkg::WORD_ZERO;
            end
        end else begin
            t <= next_t;
            s <= next_s;
            if (d_push) begin
                dsp <= dsp + stack_core_pkg::PTR_ONE;
                dstk[dsp + stack_core_pkg::PTR_ONE] <= s;
            end else if (d_pop) begin
                dsp <= dsp - stack_core_pkg::PTR_ONE;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rsp <= '0;
            r <= stack_core_pkg::WORD_ZERO;
            for (int i = 0; i < DEPTH; i++) begin
                rstk[i] <= stack_core_pkg::WORD_ZERO;
            end
        end else begin
            r <= next_r;
            if (r_push) begin
                rsp <= rsp + stack_core_pkg::PTR_ONE;
                rstk[rsp + stack_core_pkg::PTR_ONE] <= r;
            end else if (r_pop) begin
                rsp <= rsp - stack_core_pkg::PTR_ONE;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            a <= stack_core_pkg::WORD_ZERO;
        end else begin
            a <= next_a;
        end
    end

    // B reset and low nine bits on write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            b <= stack_core_pkg::B_RESET;
        end else if (b_write) begin
            b <= t[stack_core_pkg::B_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            p <= stack_core_pkg::P_RESET;
            carry <= 1'b0;
        end else begin
            p <= next_p;
            carry <= next_carry;
        end
    end

    always_ff @(posedge core_clk) begin
        if (mem_write && !eff_addr[stack_core_pkg::PORT_BIT]) begin
            if (eff_addr[stack_core_pkg::ROM_BIT]) begin
                rom[eff_addr[stack_core_pkg::MEM_IDX_W-1:0]] <= t;
            end else begin
                ram[eff_addr[stack_core_pkg::MEM_IDX_W-1:0]] <= t;
            end
        end else if (rom_load.wr) begin
            rom[rom_load.addr] <= rom_load.data;
        end
    end
endmodule // stack_core_datapath

`default_nettype wire

// file: stack_core_props.sv
// Purpose: temporal checks at the stack core datapath ports
// Assumes: one clock, reset asynchronous and active high
// Notes: bound into every datapath instance
`timescale 1ns/1ns
`default_nettype none
module stack_core_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire stack_core_pkg::op_e op,
    input wire logic p_load,
    input wire stack_core_pkg::port_req_s port_req,
    input wire logic [stack_core_pkg::WORD_W-1:0] t,
    input wire logic [stack_core_pkg::WORD_W-1:0] s,
    input wire logic [stack_core_pkg::WORD_W-1:0] r,
    input wire logic [stack_core_pkg::WORD_W-1:0] a,
    input wire logic [stack_core_pkg::B_W-1:0] b,
    input wire logic [stack_core_pkg::P_W-1:0] p,
    input wire logic carry,
    input wire logic ext_mode
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_dup_copy: assert property (op_valid && op == stack_core_pkg::OP_DUP |=> t == $past(t) && s == $past(t))
        else $error("dup result wrong");
    chk_push_return: assert property (op_valid && op == stack_core_pkg::OP_PUSH |=> r == $past(t) && t == $past(s))
        else $error("move to return wrong");
    chk_b_low_bits: assert property (op_valid && op == stack_core_pkg::OP_B_WRITE |=> b == $past(t[8:0]))
        else $error("b write wrong");
    chk_b_reset_value: assert property ($past(rst) |-> b == 9'h15D)
        else $error("b not at status address after reset");
    chk_fetch_b_port: assert property (op_valid && op == stack_core_pkg::OP_FETCH_B && b[8]
        |-> port_req.rd && port_req.addr == b ##1 b == $past(b)) else $error("fetch via b port access wrong");
    chk_a_ram_wrap: assert property (op_valid && op == stack_core_pkg::OP_FETCH_A_INC && a[8:0] == 9'h07F
        |=> a[8:0] == 9'h000) else $error("a ram wrap wrong");
    chk_p_rom_wrap: assert property (op_valid && op == stack_core_pkg::OP_FETCH_P_INC && !p_load && p[8:0] == 9'h0FF
        |=> p[8:0] == 9'h080) else $error("p rom wrap wrong");
    chk_add_plain: assert property (op_valid && op == stack_core_pkg::OP_ADD && !ext_mode
        |=> t == $past(t) + $past(s)) else $error("plain add wrong");
    chk_mul_shift: assert property (op_valid && op == stack_core_pkg::OP_MUL_STEP && !a[0]
        |=> t == {$past(t[17]), $past(t[17:1])} && a == {$past(t[0]), $past(a[17:1])}) else $error("mul step wrong");
    chk_carry_hold: assert property (!(op_valid && op == stack_core_pkg::OP_ADD && ext_mode) |=> $stable(carry))
        else $error("carry changed outside extended add");
endmodule // stack_core_props

bind stack_core_datapath stack_core_props stack_core_props_i (.core_clk, .rst, .op_valid, .op, .p_load, .port_req,
    .t, .s, .r, .a, .b, .p, .carry, .ext_mode);
`default_nettype wire

// file: op_sequencer.sv
// Purpose: model of the instruction sequencer issuing primitive ops
// Assumes: ops taken at the rising edge while op_valid is high
// Notes: drives at the falling edge only
`timescale 1ns/1ns
`default_nettype none
module op_sequencer (
    input wire logic core_clk,
    output logic op_valid,
    output stack_core_pkg::op_e op
);
    initial begin
        op_valid = 1'b0;
        op = stack_core_pkg::OP_NOP;
    end

    task automatic issue(input stack_core_pkg::op_e o);
        if (o == stack_core_pkg::OP_ADD || o == stack_core_pkg::OP_MUL_STEP) begin
            @(negedge core_clk);
            op_valid = 1'b1;
            op = stack_core_pkg::OP_NOP;
        end
        @(negedge core_clk);
        op_valid = 1'b1;
        op = o;
    endtask
endmodule // op_sequencer
`default_nettype wire

// file: testbench.sv
// Purpose: random and corner checks of the stack core datapath
// Assumes: reference model mirrors ring stacks, registers and memory
// Notes: fixed seed, so every run repeats
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic op_valid;
    stack_core_pkg::op_e op;
    logic p_load = 1'b0;
    logic [9:0] p_load_value = 10'h000;
    stack_core_pkg::rom_load_s rom_load = '0;
    logic [17:0] port_rdata = 18'h00000;
    stack_core_pkg::port_req_s port_req;
    logic [17:0] t, s, r, a, mt, ms, mr, ma, v;
    logic [17:0] ds [8], rs [8], mem [128];
    logic [8:0] b, mb;
    logic [9:0] p, mp;
    logic carry, ext_mode, mc;
    logic [2:0] dp, rp;
    logic [17:0] corner [4] = '{18'h0007F, 18'h000FF, 18'h0017F, 18'h002FF};
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 32'h0D096DC5;

    op_sequencer op_sequencer_i (.core_clk, .op_valid, .op);
    stack_core_datapath stack_core_datapath_i (.core_clk, .rst, .op_valid, .op, .p_load, .p_load_value,
        .rom_load, .port_rdata, .port_req, .t, .s, .r, .a, .b, .p, .carry, .ext_mode);

    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 12000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic dpush(input logic [17:0] x);
        dp++;
        ds[dp] = ms;
        ms = mt;
        mt = x;
    endtask

    task automatic dpop();
        mt = ms;
        ms = ds[dp];
        dp--;
    endtask

    // ports never advance; bits 8:7 keep the region so 0x7F and 0xFF wrap
    function automatic logic [17:0] incr(input logic [17:0] x);
        return x[8] ? x : {x[17:7], x[6:0] + 7'h01};
    endfunction

    task automatic acc(input logic [8:0] ad, input logic w, input logic [17:0] d, output logic [17:0] q);
        q = ad[8] ? d : mem[{ad[7], ad[5:0]}];
        if (!ad[8] && w) begin
            mem[{ad[7], ad[5:0]}] = mt;
        end
        `CHK("port_req", {!w && ad[8], w && ad[8], ad}, {port_req.rd, port_req.wr, port_req.addr})
        if (ad[8] && w) `CHK("port_wdata", mt, port_req.wdata)
    endtask

    task automatic model(input stack_core_pkg::op_e o, input logic [17:0] d);
        logic [18:0] sm;
        case (o)
            stack_core_pkg::OP_DUP: dpush(mt);
            stack_core_pkg::OP_DROP: dpop();
            stack_core_pkg::OP_OVER: dpush(ms);
            stack_core_pkg::OP_PUSH: begin
                v = mt;
                dpop();
                rp++;
                rs[rp] = mr;
                mr = v;
            end
            stack_core_pkg::OP_POP: begin
                v = mr;
                mr = rs[rp];
                rp--;
                dpush(v);
            end
            stack_core_pkg::OP_A_READ: dpush(ma);
            stack_core_pkg::OP_A_WRITE: begin
                ma = mt;
                dpop();
            end
            stack_core_pkg::OP_B_WRITE: begin
                mb = mt[8:0];
                dpop();
            end
            stack_core_pkg::OP_FETCH_A, stack_core_pkg::OP_FETCH_A_INC: begin
                acc(ma[8:0], 1'b0, d, v);
                dpush(v);
                if (o == stack_core_pkg::OP_FETCH_A_INC) ma = incr(ma);
            end
            stack_core_pkg::OP_STORE_A, stack_core_pkg::OP_STORE_A_INC: begin
                acc(ma[8:0], 1'b1, d, v);
                dpop();
                if (o == stack_core_pkg::OP_STORE_A_INC) ma = incr(ma);
            end
            stack_core_pkg::OP_FETCH_B, stack_core_pkg::OP_STORE_B: begin
                acc(mb, o == stack_core_pkg::OP_STORE_B, d, v);
                if (o == stack_core_pkg::OP_STORE_B) dpop();
                else dpush(v);
            end
            stack_core_pkg::OP_FETCH_P_INC, stack_core_pkg::OP_STORE_P_INC: begin
                acc(mp[8:0], o == stack_core_pkg::OP_STORE_P_INC, d, v);
                if (o == stack_core_pkg::OP_STORE_P_INC) dpop();
                else dpush(v);
                v = incr({8'h00, mp});
                mp = v[9:0];
            end
            stack_core_pkg::OP_NOT: mt = ~mt;
            stack_core_pkg::OP_AND, stack_core_pkg::OP_XOR: begin
                v = (o == stack_core_pkg::OP_AND) ? (mt & ms) : (mt ^ ms);
                dpop();
                mt = v;
            end
            stack_core_pkg::OP_ADD: begin
                sm = mt + ms + (mp[9] ? mc : 1'b0);
                if (mp[9]) mc = sm[18];
                dpop();
                mt = sm[17:0];
            end
            stack_core_pkg::OP_MUL_STEP: begin
                sm = {mt[17], mt} + (ma[0] ? {ms[17], ms} : 19'h00000);
                mt = sm[18:1];
                ma = {sm[0], ma[17:1]};
            end
            stack_core_pkg::OP_SHL: mt = {mt[16:0], 1'b0};
            stack_core_pkg::OP_SHR: mt = {mt[17], mt[17:1]};
            default: ;
        endcase
    endtask

    task automatic step(input stack_core_pkg::op_e o, input logic [17:0] d, input logic pl, input logic [9:0] plv);
        op_sequencer_i.issue(o);
        port_rdata = d;
        p_load = pl;
        p_load_value = plv;
        #1;
        model(o, d);
        if (pl) mp = plv;
        @(posedge core_clk);
        #1;
        `CHK("t", mt, t)
        `CHK("s", ms, s)
        `CHK("r", mr, r)
        `CHK("a", ma, a)
        `CHK("b", mb, b)
        `CHK("p", mp, p)
        `CHK("carry", mc, carry)
        `CHK("ext_mode", mp[9], ext_mode)
    endtask

    initial begin
        {mt, ms, mr, ma, mp, mc, dp, rp} = '0;
        mb = 9'h15D;
        foreach (ds[i]) begin
            ds[i] = '0;
            rs[i] = '0;
        end
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 64; i++) begin
            @(negedge core_clk);
            rom_load = {1'b1, i[5:0], 18'($random(seed))};
            mem[64 + i] = rom_load.data;
            step(stack_core_pkg::OP_NOP, 18'h00000, 1'b0, 10'h000);
        end
        @(negedge core_clk);
        rom_load = '0;
        // RAM is not reset, so fill it before any random fetch
        for (int i = 0; i < 64; i++) begin
            step(stack_core_pkg::OP_FETCH_B, 18'($random(seed)), 1'b0, 10'h000);
            step(stack_core_pkg::OP_STORE_A_INC, 18'h00000, 1'b0, 10'h000);
        end
        foreach (corner[k]) begin
            step(stack_core_pkg::OP_FETCH_B, corner[k], 1'b0, 10'h000);
            step(stack_core_pkg::OP_A_WRITE, 18'h00000, 1'b0, 10'h000);
            step(stack_core_pkg::OP_FETCH_A_INC, 18'h00000, 1'b0, 10'h000);
            step(stack_core_pkg::OP_STORE_A_INC, 18'h00000, 1'b1, corner[k][9:0]);
            step(stack_core_pkg::OP_FETCH_P_INC, 18'h00000, 1'b0, 10'h000);
            step(stack_core_pkg::OP_STORE_P_INC, 18'h00000, 1'b0, 10'h000);
            step(stack_core_pkg::OP_ADD, 18'h00000, 1'b0, 10'h000);
        end
        repeat (2500) begin
            v = 18'($random(seed));
            step(stack_core_pkg::op_e'(v[4:0]), 18'($random(seed)), v[7:5] == 3'h0, v[17:8]);
        end
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
